// file: rtl/arivec_map.svh
`ifndef ARIVEC_MAP_SVH
`define ARIVEC_MAP_SVH
// Register byte offsets on the APB bus
`define ARIVEC_OFF_ENABLE   12'h000
`define ARIVEC_OFF_PENDING  12'h004
`define ARIVEC_OFF_VECTOR   12'h008
`define ARIVEC_OFF_CTRL     12'h00c
`define ARIVEC_OFF_SLOT0    12'h040
// Control register field positions
`define ARIVEC_CTRL_OVIE    3
`define ARIVEC_CTRL_TOVIE   2
// Reset values
`define ARIVEC_RST_ENABLE   16'h0000
`define ARIVEC_RST_PENDING  16'h0000
// Vector codes
`define ARIVEC_VEC_NONE     16'h0000
`define ARIVEC_VEC_OVR      16'h0002
`define ARIVEC_VEC_TOV      16'h0004
`define ARIVEC_VEC_SLOT0    16'h0006
`endif

// file: rtl/arivec_pkg.sv
package arivec_pkg;
  // Bus phase of the APB slave
  typedef enum logic [1:0] {
    ARIVEC_IDLE   = 2'b01,
    ARIVEC_ACCESS = 2'b10
  } arivec_phase_t;
endpackage

// file: rtl/arivec_prio_if.sv
`timescale 1ns/100ps
// Sources into the priority encoder and the code it returns
interface arivec_prio_if;
  logic        ovr;     // Result overrun pending
  logic        tov;     // Overtime pending
  logic [15:0] slots;   // Enabled slot flags
  logic [15:0] code;    // Vector code
  modport enc (input ovr, tov, slots, output code);
  modport use_side (output ovr, tov, slots, input code);
endinterface

// file: rtl/arivec_prio.sv
`timescale 1ns/100ps
`include "arivec_map.svh"
// Fixed-priority encoder; purely combinational
module arivec_prio
  import arivec_pkg::*;
(
  arivec_prio_if.enc p
);
  // Code for a slot index
  function automatic logic [15:0] slot_code(input logic [3:0] n);
    slot_code = `ARIVEC_VEC_SLOT0 + {11'h000, n, 1'b0};
  endfunction

  // Overrun first, then overtime, then slot 0 upward
  always_comb begin
    p.code = `ARIVEC_VEC_NONE;
    for (int i = 15; i >= 0; i--) begin
      if (p.slots[i]) begin
        p.code = slot_code(4'(i));
      end
    end
    if (p.tov) begin
      p.code = `ARIVEC_VEC_TOV;
    end
    if (p.ovr) begin
      p.code = `ARIVEC_VEC_OVR;
    end
  end
endmodule

// file: rtl/arivec_top.sv
`timescale 1ns/100ps
`include "arivec_map.svh"
// What this block does
// - Sixteen slot enable bits mask requests
// - Result load sets slot pending flag
// - Bus access to slot clears flag
// - Software writes zero to clear flag
// - Vector codes none, overrun, overtime
// - Slot n code 6+2n, fixed priority
// - Reset clears enables and flags
// - Overrun requests need enable and global
// - Overtime requests need enable and global
module arivec_top
  import arivec_pkg::*;
(
  input  wire logic        mclk_in,          // Bus clock
  input  wire logic        nrst_in,          // Async reset, active low
  input  wire logic        psel_in,          // APB select
  input  wire logic        penable_in,       // APB enable
  input  wire logic        pwrite_in,        // APB direction
  input  wire logic [11:0] paddr_in,         // APB byte address
  input  wire logic [31:0] pwdata_in,        // APB write data
  output logic      [31:0] prdata_out,       // APB read data
  output logic             pready_out,       // APB ready
  output logic             pslverr_out,      // APB error
  input  wire logic [15:0] slot_load_in,     // Result loaded into slot, pulse
  input  wire logic [15:0] slot_access_in,   // Slot read by converter path, pulse
  input  wire logic        overrun_in,       // Result overrun event, pulse
  input  wire logic        overtime_in,      // Conversion overtime event, pulse
  input  wire logic        global_irq_enable_in, // Core global enable
  output logic             irq_out,          // Combined request
  output logic      [15:0] irq_vector_code_out // Current vector
);
  // All state in one record, registered by a single process.
  // Keeping bus answer, flags and outputs together means the
  // reset branch clears everything at once and no field can be
  // left behind in another process with a different reset.
  // The cost is that every field is copied on every clock,
  // which synthesis trims to plain enables anyway.
  typedef struct packed {
    arivec_phase_t phase;
    logic [15:0]   slot_irq_enable;
    logic [15:0]   slot_pending_flags;
    logic          ovr_flag;
    logic          tov_flag;
    logic          ovie;
    logic          tovie;
    logic [31:0]   rdata;
    logic          ready;
    logic          err;
    logic          irq;
    logic [15:0]   vec;
  } arivec_state_t;

  arivec_state_t st_reg;     // Registered state
  arivec_state_t st_next;    // Next state
  arivec_prio_if prio ();    // Encoder link

  // Hit on one of the sixteen slot words.
  // The slot words hold no data here; the result storage sits
  // in the converter's memory logic. This block only watches
  // the access so that the matching pending flag drops.
  function automatic logic slot_hit(input logic [11:0] a);
    slot_hit = (a >= `ARIVEC_OFF_SLOT0) && (a < `ARIVEC_OFF_SLOT0 + 12'h040);
  endfunction

  logic ovr_live;            // Enabled overrun request
  logic tov_live;            // Enabled overtime request
  logic [15:0] slot_live;    // Enabled slot requests

  // Masking ahead of the encoder; vector reports only what may interrupt.
  // The global enable gates only overrun and overtime; slot flags
  // are masked by their own enable bits alone.
  // Masking before the encoder keeps a disabled source from
  // hiding a lower-priority source that is enabled.
  assign ovr_live  = st_reg.ovr_flag & st_reg.ovie & global_irq_enable_in;
  assign tov_live  = st_reg.tov_flag & st_reg.tovie & global_irq_enable_in;
  assign slot_live = st_reg.slot_pending_flags & st_reg.slot_irq_enable;
  assign prio.ovr   = ovr_live;
  assign prio.tov   = tov_live;
  assign prio.slots = slot_live;

  arivec_prio u_prio (
    .p (prio.enc)
  );

  // Next-state logic.
  // Order inside this process matters: bus effects first, then
  // hardware clears, then hardware sets, so that a set event in
  // the same cycle as a clear always wins and no event is lost.
  // The request and vector outputs are computed from the current
  // flags, so they trail a flag change by one clock.
  always_comb begin
    logic       take;
    logic [3:0] idx;
    logic [15:0] clr;
    logic       vec_rd;
    take   = 1'b0;
    idx    = 4'h0;
    clr    = 16'h0000;
    vec_rd = 1'b0;
    st_next = st_reg;
    st_next.ready = 1'b0;
    st_next.err   = 1'b0;
    st_next.rdata = 32'h0000_0000;
    // Setup cycle answers one cycle later; zero wait access.
    // Ready is raised for the access cycle only; a master that
    // keeps penable high longer is not supported, since the
    // access phase always returns to idle on the next edge.
    unique case (st_reg.phase)
      ARIVEC_IDLE: begin
        if (psel_in && !penable_in) begin
          st_next.phase = ARIVEC_ACCESS;
          st_next.ready = 1'b1;
          take = 1'b1;
        end
      end
      ARIVEC_ACCESS: begin
        st_next.phase = ARIVEC_IDLE;
      end
    endcase
    if (take) begin
      idx = paddr_in[5:2];
      if (slot_hit(paddr_in)) begin
        // Any access to a slot word clears its flag; data lives elsewhere
        clr[idx] = 1'b1;
      end else if (paddr_in == `ARIVEC_OFF_ENABLE) begin
        st_next.rdata = {16'h0000, st_reg.slot_irq_enable};
        if (pwrite_in) begin
          st_next.slot_irq_enable = pwdata_in[15:0];
        end
      end else if (paddr_in == `ARIVEC_OFF_PENDING) begin
        st_next.rdata = {16'h0000, st_reg.slot_pending_flags};
        if (pwrite_in) begin
          st_next.slot_pending_flags = pwdata_in[15:0];
        end
      end else if (paddr_in == `ARIVEC_OFF_VECTOR) begin
        st_next.rdata = {16'h0000, prio.code};
        st_next.err   = pwrite_in;
        vec_rd        = !pwrite_in;
      end else if (paddr_in == `ARIVEC_OFF_CTRL) begin
        st_next.rdata = {28'h0000000, st_reg.ovie, st_reg.tovie, 2'b00};
        if (pwrite_in) begin
          st_next.ovie  = pwdata_in[`ARIVEC_CTRL_OVIE];
          st_next.tovie = pwdata_in[`ARIVEC_CTRL_TOVIE];
        end
      end else begin
        st_next.err = 1'b1; // Unmapped: error, reads zero
      end
    end
    // Reading the vector acknowledges the overrun or overtime source whose code it returns
    if (vec_rd && prio.code == `ARIVEC_VEC_OVR) begin
      st_next.ovr_flag = 1'b0;
    end
    if (vec_rd && prio.code == `ARIVEC_VEC_TOV) begin
      st_next.tov_flag = 1'b0;
    end
    // Load events win over any clear in the same cycle.
    // A software write sets the base value, then a bus slot
    // access or a converter access masks it; a load in that cycle
    // still leaves the flag set, so a fresh result is never
    // silently dropped.
    st_next.slot_pending_flags = (st_next.slot_pending_flags & ~clr & ~slot_access_in)
                                 | slot_load_in;
    if (overrun_in) begin
      st_next.ovr_flag = 1'b1;
    end
    if (overtime_in) begin
      st_next.tov_flag = 1'b1;
    end
    st_next.irq = (prio.code != `ARIVEC_VEC_NONE);
    st_next.vec = prio.code;
  end

  // State register.
  // Asynchronous reset puts every field to its idle value:
  // enables and flags clear, the bus phase returns to idle
  // and all outputs read zero until the first edge after
  // release.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
      st_reg.phase <= ARIVEC_IDLE;
      st_reg.slot_irq_enable    <= `ARIVEC_RST_ENABLE;
      st_reg.slot_pending_flags <= `ARIVEC_RST_PENDING;
    end else begin
      st_reg <= st_next;
    end
  end


  // Outputs straight from the state register; no logic sits
  // between the flops and the pins, so the core sees clean
  // levels with a full cycle of settling time.
  // Read data is zero outside the access cycle.
  assign prdata_out          = st_reg.rdata;
  assign pready_out          = st_reg.ready;
  assign pslverr_out         = st_reg.err;
  assign irq_out             = st_reg.irq;
  assign irq_vector_code_out = st_reg.vec;
endmodule

// file: verification/arivec_chk.sv
`timescale 1ns/100ps
// Port watcher: bus handshake and request outputs
module arivec_chk (
  input wire logic        mclk_in,
  input wire logic        nrst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        global_irq_enable_in,
  input wire logic        irq_out,
  input wire logic [15:0] irq_vector_code_out
);
  // One domain, so clock and reset are given once
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  a_ready_next: assert property (
    psel_in && !penable_in |=> pready_out) else $error("ready late");
  a_ready_pulse: assert property (
    pready_out |=> !pready_out) else $error("ready held");
  a_err_ready: assert property (
    pslverr_out |-> pready_out) else $error("error without ready");
  a_irq_vector: assert property (
    irq_out == (irq_vector_code_out != 16'h0000)) else $error("request and vector differ");
  a_vec_zeros: assert property (
    irq_vector_code_out[15:6] == 10'h000 && !irq_vector_code_out[0]) else $error("vector bits");
  a_vec_range: assert property (
    irq_vector_code_out <= 16'h0024) else $error("vector range");
  // Three low samples cover the flag and vector lag
  a_global_gate: assert property (
    !global_irq_enable_in [*3] |-> !(irq_vector_code_out inside {16'h0002, 16'h0004}))
    else $error("ungated overrun");
  a_reset_clear: assert property (
    $rose(nrst_in) |-> irq_vector_code_out == 16'h0000 && !irq_out) else $error("reset value");
endmodule
bind arivec_top arivec_chk u_chk (.mclk_in, .nrst_in, .psel_in, .penable_in, .pready_out,
  .pslverr_out, .global_irq_enable_in, .irq_out, .irq_vector_code_out);

// file: verification/arivec_conv_model.sv
`timescale 1ns/100ps
// Converter side: one-cycle event pulses on command, quiet otherwise
module arivec_conv_model (
  input  wire logic        mclk_in,
  input  wire logic        go_in,    // Command strobe
  input  wire logic [5:0]  sel_in,   // 0-15 load, 16-31 access, 32 overrun, 33 overtime
  output logic      [33:0] pulse_out // One-hot event pulses
);
  // Single-cycle pulse, so each event sets a flag exactly once
  always_ff @(posedge mclk_in) begin
    pulse_out <= go_in ? 34'h000000001 << sel_in : 34'h000000000;
  end
endmodule

// file: verification/adc_result_interrupt_vector_tb_top.sv
`timescale 1ns/100ps
// Bus reads note expected data; a monitor compares them
module adc_result_interrupt_vector_tb_top;
  logic        mclk_in = 1'h0, nrst_in = 1'h0, psel_in = 1'h0, penable_in = 1'h0;
  logic        pwrite_in = 1'h0, global_irq_enable_in = 1'h0, go = 1'h0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, en;
  logic [5:0]  sel = 6'h00;
  logic [33:0] pul;
  logic [15:0] irq_vector_code_out;
  logic        pready_out, pslverr_out, irq_out;
  logic [31:0] exp_q[$];
  int          n_fail = 0, comparisons = 0;
  always #12.5 mclk_in = ~mclk_in;
  arivec_top i_dut (.mclk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .slot_load_in(pul[15:0]),
    .slot_access_in(pul[31:16]), .overrun_in(pul[32]), .overtime_in(pul[33]),
    .global_irq_enable_in, .irq_out, .irq_vector_code_out);
  arivec_conv_model i_conv (.mclk_in, .go_in(go), .sel_in(sel), .pulse_out(pul));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Idle gap first lets flag and vector lag settle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    repeat (3) @(posedge mclk_in);
    if (!w) exp_q.push_back(d);
    psel_in   <= 1'h1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'h1;
    i = 0;
    do begin
      @(posedge mclk_in);
      i++;
    end while (!pready_out && i < 16);
    if (!pready_out) begin
      n_fail++;
      stop_test;
    end
    psel_in    <= 1'h0;
    penable_in <= 1'h0;
  endtask
  // Ask the converter model for one event
  task automatic ev(input logic [5:0] s);
    go  <= 1'h1;
    sel <= s;
    @(posedge mclk_in);
    go <= 1'h0;
    repeat (3) @(posedge mclk_in);
  endtask
  // Completed accesses only, read data on reads; data stands for that one cycle
  always @(posedge mclk_in) begin
    if (psel_in && penable_in && pready_out && !pwrite_in)
      check("prdata", prdata_out, exp_q.pop_front());
    if (psel_in && penable_in && pready_out)
      check("pslverr", {31'h0, pslverr_out},
        {31'h0, paddr_in == 12'h010 || (pwrite_in && paddr_in == 12'h008)});
  end
  initial begin
    int n;
    void'($urandom(53));
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'h1;
    apb(1'h0, 12'h000, 32'h0);
    apb(1'h0, 12'h004, 32'h0);
    apb(1'h0, 12'h008, 32'h0);
    en = $urandom;
    apb(1'h1, 12'h000, en);
    apb(1'h0, 12'h000, {16'h0000, en[15:0]});
    apb(1'h0, 12'h010, 32'h0);
    apb(1'h1, 12'h000, 32'h0);
    ev(6'h05);
    apb(1'h0, 12'h008, 32'h0);
    apb(1'h0, 12'h004, 32'h20);
    apb(1'h1, 12'h004, 32'h0);
    apb(1'h0, 12'h004, 32'h0);
    apb(1'h1, 12'h000, 32'hffff);
    // Odd slots cleared by converter access, even ones by a bus read
    for (n = 0; n < 16; n++) begin
      ev(6'(n));
      apb(1'h0, 12'h008, 32'(6 + 2 * n));
      if (n % 2 == 1) ev(6'(16 + n));
      else apb(1'h0, 12'(64 + 4 * n), 32'h0);
      apb(1'h0, 12'h004, 32'h0);
    end
    apb(1'h1, 12'h00c, 32'h0c);
    ev(6'h20);
    ev(6'h21);
    ev(6'h00);
    apb(1'h0, 12'h008, 32'h6);
    apb(1'h1, 12'h008, 32'h0);
    global_irq_enable_in <= 1'h1;
    apb(1'h0, 12'h008, 32'h2);
    apb(1'h0, 12'h008, 32'h4);
    apb(1'h0, 12'h008, 32'h6);
    check("irq", {31'h0, irq_out}, 32'h1);
    check("vector", {16'h0, irq_vector_code_out}, 32'h6);
    apb(1'h1, 12'h004, 32'h0);
    repeat (3) @(posedge mclk_in);
    check("irq", {31'h0, irq_out}, 32'h0);
    check("vector", {16'h0, irq_vector_code_out}, 32'h0);
    stop_test;
  end
endmodule
